// [dv/reg_host.sv]
`timescale 1ns/1ps
`default_nettype none

// register master on the far side of the block
module reg_host (
  // clock
  input wire logic clk_i,
  // register port
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // idle values at time zero
  initial begin
    addr_o = 8'h00;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // one-cycle write; stale data is inverted so it never looks valid
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask

  // one-cycle read; the data come back in the next cycle only
  task automatic get(input logic [7:0] a);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
  endtask
endmodule

`default_nettype wire

// [dv/tb_delta_angle_integrator.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_delta_angle_integrator;
  import angle_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sv = 1'b0;
  logic [31:0] rt [3] = '{32'h0, 32'h0, 32'h0};
  logic ext = 1'b0;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic upd;
  logic rd_d = 1'b0;
  logic [15:0] expq [$];
  int failures = 0;
  int checked = 0;
  int upd_cnt = 0;
  int ext_half = 0;
  int unsigned seed;
  longint acc [3];
  longint prv [3];

  // 25 MHz clock
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  reg_host host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  delta_angle_integrator #(.VARIANT(1), .INT_PERIOD(5882)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .sample_valid_i(sv),
    .rate_x_i(rt[0]), .rate_y_i(rt[1]), .rate_z_i(rt[2]), .ext_clk_i(ext),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .update_o(upd)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // |sum| * period * 2^15 / (2 * 25 MHz * 360 deg), truncated, sign restored, saturated
  function automatic logic [31:0] expv(input longint s, input int per);
    logic [127:0] m;
    m = (s < 0) ? 128'(-s) : 128'(s);
    m = m * 128'(per) * 128'h8000 / 128'h430E23400;
    if (s < 0) begin
      return (m > 128'h80000000) ? 32'h80000000 : -m[31:0];
    end
    return (m > 128'h7FFFFFFF) ? 32'h7FFFFFFF : m[31:0];
  endfunction

  // note the expectation, then issue the read
  task automatic rd_exp(input logic [7:0] a, input logic [15:0] e);
    expq.push_back(e);
    host.get(a);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (rd_d) chk(rdata, expq.pop_front());
    rd_d <= rd & ~reset_i;
    if (upd === 1'b1) upd_cnt++;
  end

  // external sample clock, free running once enabled
  initial begin
    forever begin
      @(posedge clk_i);
      if (ext_half != 0) begin
        repeat (ext_half - 1) @(posedge clk_i);
        ext <= ~ext;
      end
    end
  end

  task automatic do_reset();
    reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    prv = '{0, 0, 0};
  endtask

  task automatic zeros();
    for (int i = 0; i < 6; i++) rd_exp(8'h40 + 8'(2 * i), 16'h0000);
  endtask

  // one whole window of d+1 samples; big drives +-100 deg/s on x and y
  // (rate lsb 2^-16 deg/s) and an overrange on z to reach the clamp
  task automatic window(input logic [15:0] d, input int per, input bit big);
    int base;
    int n;
    logic [31:0] r;
    logic [31:0] w;
    logic [31:0] e;
    base = upd_cnt;
    host.put(8'h70, d);
    acc = '{0, 0, 0};
    for (int i = 0; i <= d; i++) begin
      if (i == d) chk(upd_cnt, base);
      @(posedge clk_i);
      sv <= 1'b1;
      for (int a = 0; a < 3; a++) begin
        r = $urandom();
        w = big ? 32'h00640000 : {{3{r[28]}}, r[28:0]};
        if (big && a == 1) w = -w;
        if (big && a == 2) w = 32'h40000000;
        rt[a] <= w;
        acc[a] += longint'($signed(w)) + prv[a];
        prv[a] = longint'($signed(w));
      end
      @(posedge clk_i);
      sv <= 1'b0;
    end
    n = 0;
    while (upd_cnt == base && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk(upd_cnt, base + 1);
    for (int a = 0; a < 3; a++) begin
      e = expv(acc[a], per);
      rd_exp(8'h40 + 8'(4 * a), e[15:0]);
      rd_exp(8'h42 + 8'(4 * a), e[31:16]);
    end
  endtask

  // main sequence
  initial begin
    seed = $urandom(32'h14DD27C6);
    do_reset();
    zeros();
    host.put(8'h42, 16'hFFFF);
    rd_exp(8'h42, 16'h0000);
    window(16'h0000, 5882, 1'b0);
    rd_exp(8'h74, 16'h0001);
    rd_exp(8'h74, 16'h0000);
    window(16'h0003, 5882, 1'b0);
    rd_exp(8'h70, 16'h0003);
    window(16'h1099, 5882, 1'b1);
    // faster external clock, so the host keeps the window short
    host.put(8'h72, 16'h0001);
    rd_exp(8'h72, 16'h0001);
    ext_half = 1500;
    repeat (6100) @(posedge clk_i);
    window(16'h0002, 3000, 1'b0);
    do_reset();
    zeros();
    repeat (3) @(posedge clk_i);
    complete_run();
  end

  // watchdog, well beyond the expected run of about 15000 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    complete_run();
  end
endmodule

`default_nettype wire

// [hw/angle_consts.svh]
`ifndef ANGLE_CONSTS_SVH
`define ANGLE_CONSTS_SVH

// register byte addresses, page zero
`define ADDR_X_LOW 8'h40
`define ADDR_X_HIGH 8'h42
`define ADDR_Y_LOW 8'h44
`define ADDR_Y_HIGH 8'h46
`define ADDR_Z_LOW 8'h48
`define ADDR_Z_HIGH 8'h4A
`define ADDR_DEC 8'h70
`define ADDR_CFG 8'h72
`define ADDR_STATUS 8'h74

// field positions
`define CFG_EXT_SEL_BIT 0
`define STAT_NEW_BIT 0
`define STAT_OVERRUN_BIT 1
`define STAT_BUSY_BIT 2

// reset values
`define DEC_RESET 16'h0000
`define CFG_RESET 1'b0

// timing: clock rate and internal sample rate in their own units
`define CLK_HZ 25000000
`define INT_SPS 4250
`define INT_PERIOD_CYCLES ((`CLK_HZ + (`INT_SPS / 2)) / `INT_SPS)

// full-scale ranges in degrees per variant
`define RANGE_V1 360
`define RANGE_V2 720
`define RANGE_V3 2160

// arithmetic widths
`define RATE_W 32
`define ACC_W 64
`define PER_W 16
`define FRAC_SHIFT 15
`define NUM_W 80
`define DEN_W 40
`define DIV_STEPS 7'h50
`define NUM_AXES 3

`endif

// [hw/angle_divider.sv]
`timescale 1ns/1ps
`default_nettype none
`include "angle_consts.svh"

module angle_divider
  import angle_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // request
  input wire logic start_i,
  input wire logic [`NUM_W-1:0] numer_i,
  input wire logic [`DEN_W-1:0] denom_i,
  // answer
  output logic [`NUM_W-1:0] quot_o,
  output logic done_o
);
  div_state_t st;
  div_state_t next_st;
  logic [`DEN_W:0] shift;

  // restoring divide, one quotient bit a cycle; slow but tiny
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    shift = {st.rem, st.quo[`NUM_W-1]};
    if (start_i) begin
      next_st.busy = 1'b1;
      next_st.cnt = `DIV_STEPS;
      next_st.rem = '0;
      next_st.quo = numer_i;
    end else if (st.busy) begin
      if (shift >= {1'b0, denom_i}) begin
        next_st.rem = `DEN_W'(shift - {1'b0, denom_i});
        next_st.quo = {st.quo[`NUM_W-2:0], 1'b1};
      end else begin
        next_st.rem = shift[`DEN_W-1:0];
        next_st.quo = {st.quo[`NUM_W-2:0], 1'b0};
      end
      next_st.cnt = st.cnt - 7'h01;
      if (st.cnt == 7'h01) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign quot_o = st.quo;
  assign done_o = st.done;

  a_div_latency: assert property (@(posedge clk_i) disable iff (reset_i)
    start_i |-> ##81 done_o)
    else $error("divider result not ready 81 cycles after start");
endmodule

`default_nettype wire

// [hw/angle_pkg.sv]
package angle_pkg;
  `include "angle_consts.svh"

  typedef enum logic [1:0] {
    S_COLLECT = 2'b01,
    S_DIVIDE = 2'b10
  } main_state_t;

  typedef struct packed {
    main_state_t fsm;
    logic [15:0] dec;
    logic ext_sel;
    logic [1:0] sync;
    logic ext_prev;
    logic seen_edge;
    logic per_known;
    logic [`PER_W-1:0] per_cnt;
    logic [`PER_W-1:0] per_meas;
    logic [15:0] count;
    logic [`NUM_AXES-1:0][`RATE_W-1:0] prev;
    logic [`NUM_AXES-1:0][`ACC_W-1:0] acc;
    logic [`NUM_AXES-1:0][`ACC_W-1:0] hold;
    logic div_start;
    logic [`NUM_AXES-1:0][31:0] angle;
    logic new_flag;
    logic overrun;
    logic upd;
    logic [15:0] rdata;
  } state_t;

  typedef struct packed {
    logic busy;
    logic [6:0] cnt;
    logic [`DEN_W-1:0] rem;
    logic [`NUM_W-1:0] quo;
    logic done;
  } div_state_t;
endpackage

// [hw/delta_angle_integrator.sv]
// Operation
// - each axis sums the current plus previous rate sample over the window, scaled by 1/(2*fs).
// - the window holds the decimation setting plus one samples.
// - with the internal sample clock the scaling uses 4250 samples per second.
// - with the external clock selected the scaling uses the measured external clock rate; the code uses the internal rate until an external period is measured.
// - the value range holds 100 deg/s at 4250 SPS over a 0x1099 window without overflow.
// - each axis reads as one 32-bit twos complement value split into high and low words.
// - full scale is 360, 720 or 2160 degrees, fixed by the product variant.
// - the high word reads 0x0000 at zero rotation and its lsb is full scale over 2^15.
// - the low word carries bits 15 to 0 of the 32-bit value.
// - x low word reads at 0x40, x high word at 0x42, both read-only.
// - y low word reads at 0x44, y high word at 0x46, both read-only.
// - z low word reads at 0x48, z high word at 0x4A, both read-only.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "angle_consts.svh"

module delta_angle_integrator
  import angle_pkg::*;
#(
  parameter int VARIANT = 1,
  parameter int INT_PERIOD = `INT_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // gyro rate samples, same clock domain
  input wire logic sample_valid_i,
  input wire logic [31:0] rate_x_i,
  input wire logic [31:0] rate_y_i,
  input wire logic [31:0] rate_z_i,
  // external sample clock pin
  input wire logic ext_clk_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // update pulse
  output logic update_o
);
  import angle_pkg::*;

  // full scale per variant
  localparam int RANGE_DEG = (VARIANT == 3) ? `RANGE_V3 :
                             (VARIANT == 2) ? `RANGE_V2 : `RANGE_V1;
  // lsb = range/2^31; divisor folds 2*fclk and range together
  localparam logic [63:0] DENOM64 = 64'd2 * 64'(`CLK_HZ) * 64'(RANGE_DEG);
  localparam logic [`DEN_W-1:0] DENOM = DENOM64[`DEN_W-1:0];
  localparam logic [`PER_W-1:0] INT_PER = `PER_W'(INT_PERIOD);

  state_t st;
  state_t next_st;

  logic [`NUM_AXES-1:0][31:0] rate;
  logic [`PER_W-1:0] period;
  logic ext_edge;
  logic window_end;
  logic [`NUM_AXES-1:0][`ACC_W-1:0] term;
  logic [`NUM_AXES-1:0][`NUM_W-1:0] numer;
  logic [`NUM_AXES-1:0][`NUM_W-1:0] quot;
  logic [`NUM_AXES-1:0] done;
  logic [`NUM_AXES-1:0][31:0] result;

  assign rate[0] = rate_x_i;
  assign rate[1] = rate_y_i;
  assign rate[2] = rate_z_i;

  // rising edge of the synchronised external clock; first flop never read here
  assign ext_edge = st.sync[1] & ~st.ext_prev;

  // sample interval in clk cycles: nominal internal or measured external
  assign period = (st.ext_sel && st.per_known) ? st.per_meas : INT_PER;

  assign window_end = sample_valid_i && (st.count >= st.dec);

  // per axis: trapezoid term, numerator build, divider, saturation
  for (genvar a = 0; a < `NUM_AXES; a++) begin : g_axis
    logic signed [32:0] pair;
    logic signed [49:0] prod;
    logic [`ACC_W-1:0] mag;
    logic neg;

    assign pair = $signed({rate[a][31], rate[a]}) + $signed({st.prev[a][31], st.prev[a]});
    assign prod = pair * $signed({1'b0, period});
    assign term[a] = {{14{prod[49]}}, prod};

    // divide the magnitude, restore the sign afterwards
    assign neg = st.hold[a][`ACC_W-1];
    assign mag = neg ? `ACC_W'(-st.hold[a]) : st.hold[a];
    assign numer[a] = {1'b0, mag, `FRAC_SHIFT'(0)};

    angle_divider u_div (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .start_i(st.div_start),
      .numer_i(numer[a]),
      .denom_i(DENOM),
      .quot_o(quot[a]),
      .done_o(done[a])
    );

    // clamp instead of wrapping if the host overranges the window
    always_comb begin
      if (!neg) begin
        result[a] = (|quot[a][`NUM_W-1:31]) ? 32'h7FFFFFFF : quot[a][31:0];
      end else if ((|quot[a][`NUM_W-1:32]) || (quot[a][31] && (|quot[a][30:0]))) begin
        result[a] = 32'h80000000;
      end else begin
        result[a] = 32'(-quot[a][31:0]);
      end
    end
  end

  // all next-state logic
  always_comb begin
    next_st = st;
    next_st.upd = 1'b0;
    next_st.div_start = 1'b0;
    next_st.rdata = 16'h0000;

    // two-flop synchroniser then edge history
    next_st.sync = {st.sync[0], ext_clk_i};
    next_st.ext_prev = st.sync[1];

    // external clock period measured between rising edges
    if (ext_edge) begin
      if (st.seen_edge) begin
        next_st.per_meas = st.per_cnt;
        next_st.per_known = 1'b1;
      end
      next_st.per_cnt = 16'h0001;
      next_st.seen_edge = 1'b1;
    end else if (st.per_cnt != 16'hFFFF) begin
      next_st.per_cnt = st.per_cnt + 16'h0001;
    end

    // accumulate one trapezoid term per axis per sample
    if (sample_valid_i) begin
      for (int a = 0; a < `NUM_AXES; a++) begin
        next_st.acc[a] = st.acc[a] + term[a];
        next_st.prev[a] = rate[a];
      end
      next_st.count = st.count + 16'h0001;
      if (window_end) begin
        next_st.count = 16'h0000;
        for (int a = 0; a < `NUM_AXES; a++) begin
          next_st.acc[a] = '0;
        end
        if (st.fsm == S_COLLECT) begin
          for (int a = 0; a < `NUM_AXES; a++) begin
            next_st.hold[a] = st.acc[a] + term[a];
          end
          next_st.div_start = 1'b1;
          next_st.fsm = S_DIVIDE;
        end else begin
          // window too short for the divider; this result is dropped
          next_st.overrun = 1'b1;
        end
      end
    end

    // publish all axes at once so all three axes always come from the same window
    case (st.fsm)
      S_COLLECT: begin
      end
      S_DIVIDE: begin
        if (&done) begin
          next_st.angle = result;
          next_st.upd = 1'b1;
          next_st.fsm = S_COLLECT;
        end
      end
      default: begin
        next_st.fsm = S_COLLECT;
      end
    endcase

    // register writes; data registers are read-only and ignore writes
    if (wr_i) begin
      case (addr_i)
        `ADDR_DEC: next_st.dec = wdata_i;
        `ADDR_CFG: next_st.ext_sel = wdata_i[`CFG_EXT_SEL_BIT];
        default: begin
        end
      endcase
    end

    // register reads, data one cycle later
    if (rd_i) begin
      case (addr_i)
        `ADDR_X_LOW: next_st.rdata = st.angle[0][15:0];
        `ADDR_X_HIGH: next_st.rdata = st.angle[0][31:16];
        `ADDR_Y_LOW: next_st.rdata = st.angle[1][15:0];
        `ADDR_Y_HIGH: next_st.rdata = st.angle[1][31:16];
        `ADDR_Z_LOW: next_st.rdata = st.angle[2][15:0];
        `ADDR_Z_HIGH: next_st.rdata = st.angle[2][31:16];
        `ADDR_DEC: next_st.rdata = st.dec;
        `ADDR_CFG: next_st.rdata = {15'h0000, st.ext_sel};
        `ADDR_STATUS: begin
          next_st.rdata = {13'h0000, (st.fsm == S_DIVIDE), st.overrun, st.new_flag};
          next_st.new_flag = 1'b0;
          next_st.overrun = 1'b0;
        end
        default: next_st.rdata = 16'h0000;
      endcase
    end

    // sticky flags: a set in the clearing cycle wins
    if (st.fsm == S_DIVIDE && (&done)) begin
      next_st.new_flag = 1'b1;
    end
    if (window_end && st.fsm != S_COLLECT) begin
      next_st.overrun = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
      st.fsm <= S_COLLECT;
      st.dec <= `DEC_RESET;
      st.ext_sel <= `CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign rdata_o = st.rdata;
  assign update_o = st.upd;

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // integration, publish and register read checks
  a_trap_sum_step: assert property (
    sample_valid_i && !window_end |=> st.acc[0] == $past(st.acc[0]) + $past(term[0]))
    else $error("x accumulator did not add the trapezoid term");

  a_window_close: assert property (
    sample_valid_i && st.count >= st.dec |=> st.count == 16'h0000 && st.acc[1] == '0)
    else $error("window did not close after decimation plus one samples");

  a_internal_rate: assert property (
    !st.ext_sel |-> period == INT_PER)
    else $error("internal clock selected but period differs from nominal");

  a_external_rate: assert property (
    st.ext_sel && st.per_known |-> period == st.per_meas)
    else $error("external clock selected but measured period unused");

  a_saturate_pos: assert property (
    st.fsm == S_DIVIDE && (&done) && !g_axis[2].neg && (|quot[2][`NUM_W-1:31])
      |=> st.angle[2] == 32'h7FFFFFFF)
    else $error("positive overrange not clamped");

  a_coherent_update: assert property (
    st.angle != $past(st.angle) |-> update_o)
    else $error("angle registers changed outside a window update");

  a_update_pulse: assert property (
    st.div_start |-> ##82 update_o)
    else $error("update did not follow divider start");

  a_x_low_read: assert property (
    rd_i && addr_i == `ADDR_X_LOW |=> rdata_o == $past(st.angle[0][15:0]))
    else $error("x low word read wrong");

  a_x_high_read: assert property (
    rd_i && addr_i == `ADDR_X_HIGH |=> rdata_o == $past(st.angle[0][31:16]))
    else $error("x high word read wrong");

  a_y_high_read: assert property (
    rd_i && addr_i == `ADDR_Y_HIGH |=> rdata_o == $past(st.angle[1][31:16]))
    else $error("y high word read wrong");

  a_z_low_read: assert property (
    rd_i && addr_i == `ADDR_Z_LOW |=> rdata_o == $past(st.angle[2][15:0]))
    else $error("z low word read wrong");

  a_rdata_idle: assert property (
    !rd_i |=> rdata_o == 16'h0000)
    else $error("read data present without a read");

  // register port, status, integration and publish checks
  a_y_low_read: assert property (
    rd_i && addr_i == `ADDR_Y_LOW |=> rdata_o == $past(st.angle[1][15:0]))
    else $error("y low word read wrong");

  a_z_high_read: assert property (
    rd_i && addr_i == `ADDR_Z_HIGH |=> rdata_o == $past(st.angle[2][31:16]))
    else $error("z high word read wrong");

  a_dec_write: assert property (
    wr_i && addr_i == `ADDR_DEC |=> st.dec == $past(wdata_i))
    else $error("decimation setting not taken from the write");

  a_cfg_write: assert property (
    wr_i && addr_i == `ADDR_CFG |=> st.ext_sel == $past(wdata_i[`CFG_EXT_SEL_BIT]))
    else $error("clock select not taken from the write");

  a_status_clear: assert property (
    rd_i && addr_i == `ADDR_STATUS && done != 3'b111 |=> !st.new_flag)
    else $error("new data flag survived a status read");

  a_busy_bit: assert property (
    rd_i && addr_i == `ADDR_STATUS |=> rdata_o[`STAT_BUSY_BIT] == ($past(st.fsm) == S_DIVIDE))
    else $error("status busy bit disagrees with the divider phase");

  a_period_meas: assert property (
    ext_edge && st.seen_edge |=> st.per_known && st.per_meas == $past(st.per_cnt))
    else $error("external period not captured on its rising edge");

  a_prev_sample: assert property (
    sample_valid_i |=> st.prev[2] == $past(rate_z_i))
    else $error("previous rate sample not kept for the next term");

  a_window_hold: assert property (
    window_end && st.fsm == S_COLLECT |=> st.hold[0] == $past(st.acc[0]) + $past(term[0]))
    else $error("window total not handed to the divider");

  a_div_start_once: assert property (
    st.div_start |-> st.fsm == S_DIVIDE ##1 !st.div_start)
    else $error("divider start not a single pulse in the divide phase");

  a_publish_done: assert property (
    update_o |-> $past(done) == 3'b111 && $past(st.fsm) == S_DIVIDE)
    else $error("update without all three dividers done");

  a_new_flag_set: assert property (
    update_o |-> st.new_flag)
    else $error("new data flag not set with the update");

  a_overrun_set: assert property (
    window_end && st.fsm == S_DIVIDE |=> st.overrun)
    else $error("window lost during divide did not flag overrun");
endmodule

`default_nettype wire
